// *** hsg_pkg.sv ***
// package for the hardware status group: register selectors, bit positions, reset values
package hsg_pkg;
    localparam int REG_W = 16;
    // register selectors on the status command port
    localparam logic [2:0] SEL_COND = 3'h0;
    localparam logic [2:0] SEL_PTR = 3'h1;
    localparam logic [2:0] SEL_NTR = 3'h2;
    localparam logic [2:0] SEL_EVENT = 3'h3;
    localparam logic [2:0] SEL_ENABLE = 3'h4;
    // condition bit positions
    localparam int BIT_ZERO = 15;
    localparam int BIT_RIF2 = 14;
    localparam int BIT_RIF1 = 13;
    localparam int BIT_DEC_RES = 12;
    localparam int BIT_DEC_LOW = 11;
    localparam int BIT_DEC_MEAS = 10;
    localparam int BIT_DEC_ARM = 9;
    localparam int BIT_ENC_AUX = 8;
    localparam int BIT_ENC_INFO = 7;
    localparam int BIT_COMM_SUM = 6;
    localparam int BIT_LIMIT = 5;
    localparam int BIT_SELFTEST = 4;
    localparam int BIT_OVERPWR = 3;
    localparam int BIT_UNUSED = 2;
    localparam int BIT_MIKE = 1;
    localparam int BIT_BATT = 0;
    // reset values
    localparam logic [15:0] RST_PTR = 16'hffff;
    localparam logic [15:0] RST_NTR = 16'h0000;
    localparam logic [15:0] RST_EVENT = 16'h0000;
    localparam logic [15:0] RST_ENABLE = 16'h0000;
    localparam logic [15:0] RST_COND = 16'h0000;
    // raw hardware conditions feeding the condition register
    typedef struct packed {
        logic rif2_irq;
        logic rif1_irq;
        logic dec_results;
        logic dec_level_low;
        logic dec_measuring;
        logic dec_armed;
        logic enc_two_fields;
        logic enc_sending_first;
        logic enc_sending_second;
        logic enc_fgen_mode;
        logic comm_summary;
        logic meas_over_high;
        logic meas_under_low;
        logic selftest_failed;
        logic overpower;
        logic mike_keyed;
        logic battery_low;
    } hsg_hw_t;
    // one status command
    typedef struct packed {
        logic rd;
        logic wr;
        logic [2:0] sel;
        logic [15:0] data;
    } hsg_cmd_t;
endpackage

// *** hsg_status_group.sv ***
// hardware status group one: condition, transition filters, event, enable, summary
`timescale 1ns/1ns
// What this block does
// - sixteen-bit condition, positive and negative filters, event and enable, plus summary.
// - event register clears on any query of it and on clear-status.
// - condition bit 15 always reads zero.
// - bit 14 follows radio card interrupt two, bit 13 interrupt one.
// - bits 12..9 give decoder results, level low, measuring, armed.
// - bit 8 set when a two-field format sends both fields.
// - bit 7 set when one field is sent, of either format.
// - bit 7 forced inactive in function-generator encoder mode.
// - bit 6 carries the communication group summary.
// - bit 5 set when a measurement passes upper or lower limit.
// - bits 4,3,1,0 self test, overpower, mike, battery; bit 2 unused.
// - controller reads condition, event, filters; writes filters; device returns contents.
// - enable keeps last written mask; writing zero clears it.
module hsg_status_group
    import hsg_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // hardware conditions
    input hsg_hw_t hw,
    // status commands
    input hsg_cmd_t cmd,
    input wire logic clear_status,
    // answers
    output logic [15:0] rd_data,
    output logic rd_valid,
    output logic summary
);

    ////////////////////////////////////////////////////////////////////////
    // condition assembly
    logic [15:0] cond_now;
    always_comb begin
        cond_now = 16'h0000;
        cond_now[BIT_ZERO] = 1'b0;
        cond_now[BIT_RIF2] = hw.rif2_irq;
        cond_now[BIT_RIF1] = hw.rif1_irq;
        cond_now[BIT_DEC_RES] = hw.dec_results;
        cond_now[BIT_DEC_LOW] = hw.dec_level_low;
        cond_now[BIT_DEC_MEAS] = hw.dec_measuring;
        cond_now[BIT_DEC_ARM] = hw.dec_armed;
        cond_now[BIT_ENC_AUX] = hw.enc_two_fields & hw.enc_sending_first
                                & hw.enc_sending_second;
        // one field only, either format; never in generator mode
        cond_now[BIT_ENC_INFO] = ~hw.enc_fgen_mode
                                 & (hw.enc_sending_first ^ hw.enc_sending_second);
        cond_now[BIT_COMM_SUM] = hw.comm_summary;
        cond_now[BIT_LIMIT] = hw.meas_over_high | hw.meas_under_low;
        cond_now[BIT_SELFTEST] = hw.selftest_failed;
        cond_now[BIT_OVERPWR] = hw.overpower;
        cond_now[BIT_UNUSED] = 1'b0;
        cond_now[BIT_MIKE] = hw.mike_keyed;
        cond_now[BIT_BATT] = hw.battery_low;
    end

    ////////////////////////////////////////////////////////////////////////
    // register state
    logic [15:0] cond_q, cond_d;
    logic [15:0] ptr_q, ptr_d;
    logic [15:0] ntr_q, ntr_d;
    logic [15:0] event_q, event_d;
    logic [15:0] enable_q, enable_d;
    logic [15:0] rd_data_d;
    logic rd_valid_d;
    logic summary_d;
    logic [15:0] rise;
    logic [15:0] fall;
    logic [15:0] hits;

    // an event register query also clears it, so the decode is shared
    function automatic logic event_query(input hsg_cmd_t c);
        return c.rd && (c.sel == SEL_EVENT);
    endfunction

    // next values of all registers
    always_comb begin
        cond_d = cond_now;
        ptr_d = ptr_q;
        ntr_d = ntr_q;
        enable_d = enable_q;
        rise = cond_now & ~cond_q;
        fall = ~cond_now & cond_q;
        hits = (rise & ptr_q) | (fall & ntr_q);
        event_d = event_q;
        if (clear_status || event_query(cmd)) begin
            event_d = 16'h0000;
        end
        event_d = event_d | hits; // new edge wins over the clear
        if (cmd.wr) begin
            case (cmd.sel)
                SEL_PTR: ptr_d = cmd.data;
                SEL_NTR: ntr_d = cmd.data;
                SEL_ENABLE: enable_d = cmd.data;
                default: ;
            endcase
        end
        rd_valid_d = cmd.rd;
        case (cmd.sel)
            SEL_COND: rd_data_d = cond_q;
            SEL_PTR: rd_data_d = ptr_q;
            SEL_NTR: rd_data_d = ntr_q;
            SEL_EVENT: rd_data_d = event_q;
            SEL_ENABLE: rd_data_d = enable_q;
            default: rd_data_d = 16'h0000;
        endcase
        if (!cmd.rd) begin
            rd_data_d = rd_data;
        end
        summary_d = |(event_d & enable_d);
    end

    // registers
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cond_q <= RST_COND;
            ptr_q <= RST_PTR;
            ntr_q <= RST_NTR;
            event_q <= RST_EVENT;
            enable_q <= RST_ENABLE;
            rd_data <= 16'h0000;
            rd_valid <= 1'b0;
            summary <= 1'b0;
        end else begin
            cond_q <= cond_d;
            ptr_q <= ptr_d;
            ntr_q <= ntr_d;
            event_q <= event_d;
            enable_q <= enable_d;
            rd_data <= rd_data_d;
            rd_valid <= rd_valid_d;
            summary <= summary_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_bit15_zero;
        @(posedge clk_sys) disable iff (reset) cond_q[BIT_ZERO] == 1'b0 && event_q[BIT_ZERO] == 1'b0;
    endproperty
    a_bit15_zero: assert property (p_bit15_zero) else $error("bit 15 not zero");

    property p_event_query_clears;
        @(posedge clk_sys) disable iff (reset)
            (event_query(cmd) && hits == 16'h0000) |=> event_q == 16'h0000;
    endproperty
    a_event_query_clears: assert property (p_event_query_clears) else $error("event not cleared");

    property p_cls_clears;
        @(posedge clk_sys) disable iff (reset) (clear_status && hits == 16'h0000) |=> event_q == 16'h0000;
    endproperty
    a_cls_clears: assert property (p_cls_clears) else $error("clear status failed");

    property p_rise_sets;
        @(posedge clk_sys) disable iff (reset) (|(cond_now & ~cond_q & ptr_q)) |=> (|event_q);
    endproperty
    a_rise_sets: assert property (p_rise_sets) else $error("rise not latched");

    property p_event_sticky;
        @(posedge clk_sys) disable iff (reset)
            (!clear_status && !event_query(cmd)) |=> (event_q & $past(event_q)) == $past(event_q);
    endproperty
    a_event_sticky: assert property (p_event_sticky) else $error("event bit lost");

    property p_summary;
        @(posedge clk_sys) disable iff (reset) ##1 summary == |(event_q & enable_q);
    endproperty
    a_summary: assert property (p_summary) else $error("summary wrong");

    property p_fgen_info_off;
        @(posedge clk_sys) disable iff (reset) hw.enc_fgen_mode |=> !cond_q[BIT_ENC_INFO];
    endproperty
    a_fgen_info_off: assert property (p_fgen_info_off) else $error("info bit in generator mode");

    property p_enable_write;
        @(posedge clk_sys) disable iff (reset)
            (cmd.wr && cmd.sel == SEL_ENABLE) |=> enable_q == $past(cmd.data);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable not written");

    property p_read_answer;
        @(posedge clk_sys) disable iff (reset)
            (cmd.rd && cmd.sel == SEL_PTR) |=> rd_valid && rd_data == $past(ptr_q);
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read data wrong");

    property p_aux_bit;
        @(posedge clk_sys) disable iff (reset)
            (hw.enc_two_fields && hw.enc_sending_first && hw.enc_sending_second) |=> cond_q[BIT_ENC_AUX];
    endproperty
    a_aux_bit: assert property (p_aux_bit) else $error("aux bit missing");

    // an edge in the cycle of a clear or query must still land
    property p_set_wins;
        @(posedge clk_sys) disable iff (reset) (hits != 16'h0000) |=> (event_q & $past(hits)) == $past(hits);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event edge lost to clear");

    property p_ptr_write;
        @(posedge clk_sys) disable iff (reset) (cmd.wr && cmd.sel == SEL_PTR) |=> ptr_q == $past(cmd.data);
    endproperty
    a_ptr_write: assert property (p_ptr_write) else $error("positive filter not written");

    property p_ntr_write;
        @(posedge clk_sys) disable iff (reset) (cmd.wr && cmd.sel == SEL_NTR) |=> ntr_q == $past(cmd.data);
    endproperty
    a_ntr_write: assert property (p_ntr_write) else $error("negative filter not written");

    property p_radio_bits;
        @(posedge clk_sys) disable iff (reset)
            ##1 cond_q[BIT_RIF2] == $past(hw.rif2_irq) && cond_q[BIT_RIF1] == $past(hw.rif1_irq);
    endproperty
    a_radio_bits: assert property (p_radio_bits) else $error("radio interrupt bits wrong");

    property p_limit_bit;
        @(posedge clk_sys) disable iff (reset) (hw.meas_over_high || hw.meas_under_low) |=> cond_q[BIT_LIMIT];
    endproperty
    a_limit_bit: assert property (p_limit_bit) else $error("limit bit missing");

    property p_unused_bit;
        @(posedge clk_sys) disable iff (reset) cond_q[BIT_UNUSED] == 1'b0;
    endproperty
    a_unused_bit: assert property (p_unused_bit) else $error("unused bit set");

    // answer strobe only follows a query
    property p_valid_quiet;
        @(posedge clk_sys) disable iff (reset) !cmd.rd |=> !rd_valid;
    endproperty
    a_valid_quiet: assert property (p_valid_quiet) else $error("answer without query");

    // event query returns the contents before its own clear
    property p_event_read;
        @(posedge clk_sys) disable iff (reset) event_query(cmd) |=> rd_valid && rd_data == $past(event_q);
    endproperty
    a_event_read: assert property (p_event_read) else $error("event read data wrong");

endmodule // hsg_status_group

// *** hsg_ctl_model.sv ***
// controller model issuing status commands to the hardware status group
`timescale 1ns/1ns
module hsg_ctl_model
    import hsg_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // answers from the group
    input wire logic [15:0] rd_data,
    input wire logic rd_valid,
    // commands to the group
    output hsg_cmd_t cmd,
    output logic clear_status
);
    // idle command lines at time zero
    initial begin
        cmd = '0;
        clear_status = 1'b0;
    end
    // one query; answer taken after the edge that takes it
    task automatic query(input logic [2:0] sel, output logic [15:0] data, output logic ok);
        @(negedge clk_sys);
        cmd = '{1'b1, 1'b0, sel, 16'h5a5a};
        @(negedge clk_sys);
        cmd.rd = 1'b0;
        ok = rd_valid;
        data = rd_data;
    endtask
    // one write of an integer value; zero clears the enable mask
    task automatic write(input logic [2:0] sel, input logic [15:0] val);
        @(negedge clk_sys);
        cmd = '{1'b0, 1'b1, sel, val};
        @(negedge clk_sys);
        cmd.wr = 1'b0;
        cmd.data = ~val; // released data no longer shows the value
    endtask
    // clear-status common command, one cycle
    task automatic clear();
        @(negedge clk_sys);
        clear_status = 1'b1;
        @(negedge clk_sys);
        clear_status = 1'b0;
    endtask
endmodule // hsg_ctl_model

// *** hardware_status_group_tb.sv ***
// testbench for the hardware status group
`timescale 1ns/1ns
module hardware_status_group_tb;
    import hsg_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    hsg_hw_t hw = '0;
    hsg_cmd_t cmd;
    logic clear_status, rd_valid, summary, ok;
    logic [15:0] rd_data, got;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    // raw condition patterns and the condition word each must give
    logic [16:0] hw_tab [18] = '{17'h10000, 17'h08000, 17'h04000, 17'h02000, 17'h01000, 17'h00800,
        17'h00700, 17'h00200, 17'h00600, 17'h00280, 17'h00040, 17'h00020, 17'h00010, 17'h00008,
        17'h00004, 17'h00002, 17'h00001, 17'h1ffff};
    logic [15:0] cond_tab [18] = '{16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h0400, 16'h0200,
        16'h0100, 16'h0080, 16'h0080, 16'h0000, 16'h0040, 16'h0020, 16'h0020, 16'h0010,
        16'h0008, 16'h0002, 16'h0001, 16'h7f7b};
    // clock
    always #5 clk_sys = ~clk_sys;
    hsg_status_group i_dut (.clk_sys(clk_sys), .reset(reset), .hw(hw), .cmd(cmd),
        .clear_status(clear_status), .rd_data(rd_data), .rd_valid(rd_valid), .summary(summary));
    hsg_ctl_model i_ctl (.clk_sys(clk_sys), .rd_data(rd_data), .rd_valid(rd_valid), .cmd(cmd),
        .clear_status(clear_status));
    // verdict and end of run
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // compare and count
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    // query a register and compare the answer
    task automatic rd_chk(input logic [2:0] sel, input logic [15:0] e);
        i_ctl.query(sel, got, ok);
        chk({15'h0000, ok}, 16'h0001);
        chk(got, e);
    endtask
    // cut a hang short
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            print_verdict();
        end
    end
    // main sequence
    initial begin
        repeat (20) @(negedge clk_sys);
        reset = 1'b0;
        rd_chk(SEL_PTR, 16'hffff);
        rd_chk(SEL_NTR, 16'h0000);
        rd_chk(SEL_ENABLE, 16'h0000);
        rd_chk(SEL_EVENT, 16'h0000);
        // every condition bit, its rising event, then clear by query
        for (int i = 0; i < 18; i++) begin
            hw = hw_tab[i];
            repeat (2) @(negedge clk_sys);
            rd_chk(SEL_COND, cond_tab[i]);
            rd_chk(SEL_EVENT, cond_tab[i]);
            rd_chk(SEL_EVENT, 16'h0000);
            hw = '0;
            repeat (2) @(negedge clk_sys);
        end
        // filters and mask on the battery bit; condition write is ignored
        i_ctl.write(SEL_PTR, 16'h0000);
        i_ctl.write(SEL_NTR, 16'h0001);
        i_ctl.write(SEL_ENABLE, 16'h0001);
        i_ctl.write(SEL_COND, 16'hffff);
        rd_chk(SEL_PTR, 16'h0000);
        rd_chk(SEL_NTR, 16'h0001);
        rd_chk(SEL_ENABLE, 16'h0001);
        rd_chk(SEL_COND, 16'h0000);
        hw.battery_low = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk({15'h0000, summary}, 16'h0000);
        hw.battery_low = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk({15'h0000, summary}, 16'h0001);
        i_ctl.clear();
        chk({15'h0000, summary}, 16'h0000);
        rd_chk(SEL_EVENT, 16'h0000);
        hw.battery_low = 1'b1;
        repeat (2) @(negedge clk_sys);
        hw.battery_low = 1'b0;
        repeat (2) @(negedge clk_sys);
        rd_chk(SEL_EVENT, 16'h0001);
        chk({15'h0000, summary}, 16'h0000);
        i_ctl.write(SEL_ENABLE, 16'h0000);
        rd_chk(SEL_ENABLE, 16'h0000);
        // refused event write, zero answer to an unused selector, then an edge in the cycle of an event query
        i_ctl.write(SEL_EVENT, 16'hffff);
        rd_chk(SEL_EVENT, 16'h0000);
        rd_chk(3'h5, 16'h0000);
        i_ctl.write(SEL_PTR, 16'hffff);
        fork
            rd_chk(SEL_EVENT, 16'h0000);
            begin
                @(negedge clk_sys);
                hw.mike_keyed = 1'b1;
            end
        join
        rd_chk(SEL_EVENT, 16'h0002);
        hw.mike_keyed = 1'b0;
        print_verdict();
    end
endmodule // hardware_status_group_tb
